// File: rtc_calendar.sv
// calendar clock with alarm, square wave and two-wire slave
`timescale 1ns/1ps
`include "rtc_defines.svh"
module rtc_calendar #(
    parameter logic [6:0] DEV_ADDR = `DEV_ADDR,
    parameter int OSC_FAIL_CYC = `OSC_FAIL_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // crystal
    input wire logic i_xtal,
    // two-wire bus
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oen,
    // open-drain outputs
    output logic o_irq_out,
    output logic o_irq_oen,
    output logic o_square_wave_out,
    output logic o_square_wave_oen,
    // status
    output logic o_osc_fail
);
    rtc_pkg::rtc_state_t q;
    rtc_pkg::rtc_state_t d;
    logic scl_rise, scl_fall, start, stop, tick, hit, osf_set, wr, wave;
    logic [3:0] wptr;
    logic [7:0] wdat;
    logic [3:0] en;
    logic [3:0] mt;
    logic [8:0] t9;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] max,
                                           input logic [7:0] min, input logic en_i);
        if (!en_i)
            bcd_inc = {1'b0, v};
        else if (v >= max)
            bcd_inc = {1'b1, min};
        else if (v[3:0] == 4'h9)
            bcd_inc = {1'b0, 4'(v[7:4] + 4'h1), 4'h0};
        else
            bcd_inc = {1'b0, 8'(v + 8'h01)};
    endfunction

    function automatic logic is_leap(input logic [7:0] y);
        if (!y[4])
            is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        else
            is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    endfunction

    function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
        if (m == 8'h02)
            month_end = is_leap(y) ? 8'h29 : 8'h28;
        else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
            month_end = 8'h30;
        else
            month_end = 8'h31;
    endfunction

    function automatic logic [7:0] rd_reg(input rtc_pkg::rtc_state_t s, input logic [3:0] p);
        if (p == `REG_CTRL2)
            rd_reg = {4'h0, s.alarm_pending_flag, 1'b0, s.alarm_irq_enable, 1'b0};
        else if (p == `REG_SEC)
            rd_reg = {s.osc_fail_flag, s.sec[6:0]};
        else if (p == `REG_MIN)
            rd_reg = s.min;
        else if (p == `REG_HOUR)
            rd_reg = s.hour;
        else if (p == `REG_DATE)
            rd_reg = s.date;
        else if (p == `REG_WDAY)
            rd_reg = s.wday;
        else if (p == `REG_MON)
            rd_reg = s.mon;
        else if (p == `REG_YEAR)
            rd_reg = s.year;
        else if (p == `REG_AL_MIN)
            rd_reg = s.al_min;
        else if (p == `REG_AL_HOUR)
            rd_reg = s.al_hour;
        else if (p == `REG_AL_DATE)
            rd_reg = s.al_date;
        else if (p == `REG_AL_WDAY)
            rd_reg = s.al_wday;
        else if (p == `REG_WAVE)
            rd_reg = {s.square_wave_enable, 5'h00, s.square_wave_rate_select};
        else
            rd_reg = 8'h00;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        d = q;
        wr = 1'b0;
        wptr = 4'h0;
        wdat = 8'h00;
        t9 = 9'h000;
        // pins pass two flops before any logic looks at them
        d.scl_m = i_scl;
        d.scl_s = q.scl_m;
        d.scl_p = q.scl_s;
        d.sda_m = i_sda;
        d.sda_s = q.sda_m;
        d.sda_p = q.sda_s;
        d.xtal_m = i_xtal;
        d.xtal_s = q.xtal_m;
        d.xtal_p = q.xtal_s;
        scl_rise = q.scl_s & ~q.scl_p;
        scl_fall = ~q.scl_s & q.scl_p;
        start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
        stop = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;

        // crystal prescaler; a missing edge for too long means a dead oscillator
        tick = 1'b0;
        if (q.xtal_s & ~q.xtal_p)
        begin
            d.pre = 15'(q.pre + 15'h0001);
            d.wdog = 20'h00000;
            tick = (q.pre == 15'h7FFF);
        end
        else if (q.wdog != 20'(OSC_FAIL_CYC))
            d.wdog = 20'(q.wdog + 20'h00001);
        osf_set = (q.wdog == 20'(OSC_FAIL_CYC));

        // second tick ripples up the chain
        t9 = bcd_inc(q.sec, `SEC_MAX, 8'h00, tick);
        d.sec = t9[7:0];
        t9 = bcd_inc(q.min, `SEC_MAX, 8'h00, t9[8]);
        d.min = t9[7:0];
        t9 = bcd_inc(q.hour, `HOUR_MAX, 8'h00, t9[8]);
        d.hour = t9[7:0];
        if (t9[8])
            d.wday = (q.wday >= `WDAY_MAX) ? 8'h00 : 8'(q.wday + 8'h01);
        t9 = bcd_inc(q.date, month_end(q.mon, q.year), `RST_DAY_ONE, t9[8]);
        d.date = t9[7:0];
        t9 = bcd_inc(q.mon, `MON_MAX, `RST_DAY_ONE, t9[8]);
        d.mon = t9[7:0];
        t9 = bcd_inc(q.year, `YEAR_MAX, 8'h00, t9[8]);
        d.year = t9[7:0];

        // alarm checked once per minute, at the roll to second 00
        en = ~{q.al_min[`BIT_FIELD_OFF], q.al_hour[`BIT_FIELD_OFF],
               q.al_date[`BIT_FIELD_OFF], q.al_wday[`BIT_FIELD_OFF]};
        mt = {q.al_min[6:0] == d.min[6:0], q.al_hour[5:0] == d.hour[5:0],
              q.al_date[5:0] == d.date[5:0], q.al_wday[2:0] == d.wday[2:0]};
        hit = tick && (d.sec == 8'h00) && (en != 4'h0) && ((mt | ~en) == 4'hF);

        // two-wire slave
        if (start)
        begin
            d.st = rtc_pkg::st_addr;
            d.bit_cnt = 4'h0;
            d.sda_drv = 1'b0;
        end
        else if (stop)
        begin
            d.st = rtc_pkg::st_idle;
            d.sda_drv = 1'b0;
        end
        else if (scl_rise && q.st != rtc_pkg::st_idle)
        begin
            d.shift = {q.shift[6:0], q.sda_s};
            d.bit_cnt = 4'(q.bit_cnt + 4'h1);
        end
        else if (scl_fall)
        begin
            case (q.st)
                rtc_pkg::st_addr:
                    if (q.bit_cnt == 4'h8)
                    begin
                        d.st = (q.shift[7:1] == DEV_ADDR) ? rtc_pkg::st_ack_addr : rtc_pkg::st_idle;
                        d.sda_drv = (q.shift[7:1] == DEV_ADDR);
                        d.read_dir = q.shift[0];
                    end
                rtc_pkg::st_ack_addr:
                begin
                    d.bit_cnt = 4'h0;
                    d.tx = rd_reg(q, q.ptr);
                    d.sda_drv = q.read_dir & ~d.tx[7];
                    d.st = q.read_dir ? rtc_pkg::st_rd : rtc_pkg::st_reg;
                end
                rtc_pkg::st_reg:
                    if (q.bit_cnt == 4'h8)
                    begin
                        // out-of-range pointer is left unanswered
                        d.st = (q.shift <= `REG_ADDR_MAX) ? rtc_pkg::st_ack : rtc_pkg::st_idle;
                        d.sda_drv = (q.shift <= `REG_ADDR_MAX);
                        d.ptr = (q.shift <= `REG_ADDR_MAX) ? q.shift[3:0] : q.ptr;
                    end
                rtc_pkg::st_ack:
                begin
                    d.sda_drv = 1'b0;
                    d.bit_cnt = 4'h0;
                    d.st = rtc_pkg::st_wr;
                end
                rtc_pkg::st_wr:
                    if (q.bit_cnt == 4'h8)
                    begin
                        wr = 1'b1;
                        wptr = q.ptr;
                        wdat = q.shift;
                        d.ptr = 4'(q.ptr + 4'h1);
                        d.sda_drv = 1'b1;
                        d.st = rtc_pkg::st_ack;
                    end
                rtc_pkg::st_rd:
                    if (q.bit_cnt == 4'h8)
                    begin
                        d.sda_drv = 1'b0;
                        d.st = rtc_pkg::st_mack;
                    end
                    else
                    begin
                        d.tx = {q.tx[6:0], 1'b0};
                        d.sda_drv = ~q.tx[6];
                    end
                rtc_pkg::st_mack:
                    if (!q.shift[0])
                    begin
                        d.ptr = 4'(q.ptr + 4'h1);
                        d.tx = rd_reg(q, d.ptr);
                        d.sda_drv = ~d.tx[7];
                        d.bit_cnt = 4'h0;
                        d.st = rtc_pkg::st_rd;
                    end
                    else
                        d.st = rtc_pkg::st_idle;
                default:
                    d.st = rtc_pkg::st_idle;
            endcase
        end

        // host writes win over the tick that lands in the same cycle
        if (wr)
        begin
            if (wptr == `REG_CTRL2)
            begin
                d.alarm_irq_enable = wdat[`BIT_IRQ_EN];
                if (!wdat[`BIT_ALARM_FLAG])
                    d.alarm_pending_flag = 1'b0;
            end
            else if (wptr == `REG_SEC)
            begin
                d.sec = wdat & `MASK_SEC;
                d.pre = 15'h0000;
                if (!wdat[`BIT_OSC_FAIL])
                    d.osc_fail_flag = 1'b0;
            end
            else if (wptr == `REG_MIN)
                d.min = wdat & `MASK_SEC;
            else if (wptr == `REG_HOUR)
                d.hour = wdat & `MASK_HOUR;
            else if (wptr == `REG_DATE)
                d.date = wdat & `MASK_HOUR;
            else if (wptr == `REG_WDAY)
                d.wday = wdat & `MASK_WDAY;
            else if (wptr == `REG_MON)
                d.mon = wdat & `MASK_MON;
            else if (wptr == `REG_YEAR)
                d.year = wdat;
            else if (wptr == `REG_AL_MIN)
                d.al_min = wdat;
            else if (wptr == `REG_AL_HOUR)
                d.al_hour = wdat & `MASK_AL_HOUR;
            else if (wptr == `REG_AL_DATE)
                d.al_date = wdat & `MASK_AL_HOUR;
            else if (wptr == `REG_AL_WDAY)
                d.al_wday = wdat & `MASK_AL_WDAY;
            else if (wptr == `REG_WAVE)
            begin
                d.square_wave_enable = wdat[`BIT_WAVE_EN];
                d.square_wave_rate_select = wdat[1:0];
            end
        end
        // set beats a clear in the same cycle
        if (hit)
            d.alarm_pending_flag = 1'b1;
        if (osf_set)
            d.osc_fail_flag = 1'b1;

        if (q.square_wave_rate_select == `RATE_32K)
            wave = q.xtal_s;
        else if (q.square_wave_rate_select == `RATE_1K)
            wave = q.pre[`PRE_BIT_1K];
        else if (q.square_wave_rate_select == `RATE_32)
            wave = q.pre[`PRE_BIT_32];
        else
            wave = q.pre[`PRE_BIT_1];
        d.wave_drv = q.square_wave_enable & ~wave;
        d.irq_drv = q.alarm_pending_flag & q.alarm_irq_enable;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            q <= '0;
            q.square_wave_enable <= `RST_WAVE_EN;
            q.square_wave_rate_select <= `RST_RATE;
            q.osc_fail_flag <= `RST_OSC_FAIL;
            q.date <= `RST_DAY_ONE;
            q.mon <= `RST_DAY_ONE;
            q.al_min <= `RST_AL_FIELD;
            q.al_hour <= `RST_AL_FIELD;
            q.al_date <= `RST_AL_FIELD;
            q.al_wday <= `RST_AL_FIELD;
        end
        else
            q <= d;
    end

    // open drain: only ever pull low
    assign o_sda_out = 1'b0;
    assign o_sda_oen = ~q.sda_drv;
    assign o_irq_out = 1'b0;
    assign o_irq_oen = ~q.irq_drv;
    assign o_square_wave_out = 1'b0;
    assign o_square_wave_oen = ~q.wave_drv;
    assign o_osc_fail = q.osc_fail_flag;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_flag_clear;
        wr && wptr == `REG_CTRL2 && !wdat[`BIT_ALARM_FLAG] && !hit;
    endsequence
    sequence s_feb_last;
        tick && !wr && q.mon == 8'h02 && q.date == 8'h28 && q.hour == `HOUR_MAX
            && q.min == `SEC_MAX && q.sec == `SEC_MAX;
    endsequence
    sequence s_addr_match;
        scl_fall && !start && !stop && q.st == rtc_pkg::st_addr && q.bit_cnt == 4'h8
            && q.shift[7:1] == DEV_ADDR;
    endsequence
    sequence s_bad_reg;
        scl_fall && !start && !stop && q.st == rtc_pkg::st_reg && q.bit_cnt == 4'h8
            && q.shift > `REG_ADDR_MAX;
    endsequence

    a_flag_clear: assert property (s_flag_clear |=> !q.alarm_pending_flag)
        else $error("alarm flag not cleared by write of 0");
    a_alarm_irq: assert property (hit && q.alarm_irq_enable && !wr |=> ##1 !o_irq_oen)
        else $error("interrupt pin not pulled after alarm");
    a_fields_off: assert property (en == 4'h0 && !q.alarm_pending_flag |=> !q.alarm_pending_flag)
        else $error("alarm fired with every field disabled");
    a_leap_feb: assert property (s_feb_last |=> q.date == (is_leap(q.year) ? 8'h29 : 8'h01))
        else $error("february end wrong");
    a_sec_wrap: assert property (tick && !wr && q.sec == `SEC_MAX |=> q.sec == 8'h00 && q.min != $past(q.min))
        else $error("seconds did not carry");
    a_addr_ack: assert property (s_addr_match |=> !o_sda_oen)
        else $error("own address not acknowledged");
    a_reg_nack: assert property (s_bad_reg |=> o_sda_oen)
        else $error("out of range register acknowledged");
    a_idle_release: assert property (q.st == rtc_pkg::st_idle |-> o_sda_oen)
        else $error("data line held while idle");
    a_wave_off: assert property (!q.square_wave_enable [*2] |-> o_square_wave_oen)
        else $error("square wave pin driven while disabled");
    a_osc_fail: assert property (osf_set |=> q.osc_fail_flag ##1 (q.osc_fail_flag || $past(wr)))
        else $error("oscillator fail flag not set");
endmodule

// File: rtc_calendar_tb.sv
// self-checking bench: register access, square wave, oscillator fail
`timescale 1ns/1ps
module rtc_calendar_tb;
    // bus address, value is arbitrary
    localparam logic [6:0] DEV = 7'h2C;
    localparam int FAIL_CYC = 200;
    localparam int MAX_CYC = 60000;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic xtal = 1'b0;
    logic xtal_run = 1'b1;
    logic scl;
    logic sda_pull;
    logic sda;
    logic sda_oen;
    logic sda_out;
    logic irq_out;
    logic wave_out;
    logic irq_oen;
    logic wave_oen;
    logic osc_fail;
    logic ack;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int lo_tab [5] = '{62, 1, 0, 0, 0};
    int hi_tab [5] = '{66, 3, 1, 1, 0};
    logic [7:0] ctl_tab [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h03};
    ////////////////////////////////////////////////////////////////////////////
    always #2.5 clk = ~clk;
    // crystal at 40 ns, moved 1 ns after the clock edge
    initial
    begin
        #3.5;
        forever #20 if (xtal_run) xtal = ~xtal;
    end
    // pull-up on the data line; either party may pull it low
    assign sda = sda_pull ? 1'b0 : (!sda_oen ? sda_out : 1'b1);
    rtc_calendar #(
        .DEV_ADDR(DEV),
        .OSC_FAIL_CYC(FAIL_CYC)
    ) i_rtc_calendar (
        .i_clk(clk),
        .i_srst(srst),
        .i_xtal(xtal),
        .i_scl(scl),
        .i_sda(sda),
        .o_sda_out(sda_out),
        .o_sda_oen(sda_oen),
        .o_irq_out(irq_out),
        .o_irq_oen(irq_oen),
        .o_square_wave_out(wave_out),
        .o_square_wave_oen(wave_oen),
        .o_osc_fail(osc_fail)
    );
    rtc_host_model i_rtc_host_model (
        .o_scl(scl),
        .o_sda_pull(sda_pull),
        .i_sda(sda)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == MAX_CYC)
        begin
            errors++;
            complete_run();
        end
    end
    task automatic reg_write(input logic [7:0] p, input logic [7:0] d [$]);
        logic a;
        i_rtc_host_model.start();
        i_rtc_host_model.wbyte({DEV, 1'b0}, a);
        check({7'h00, a}, 8'h01);
        i_rtc_host_model.wbyte(p, a);
        check({7'h00, a}, 8'h01);
        foreach (d[k])
        begin
            i_rtc_host_model.wbyte(d[k], a);
            check({7'h00, a}, 8'h01);
        end
        i_rtc_host_model.stop();
    endtask
    // pointer write, repeated start, then a burst read
    task automatic reg_read(input logic [7:0] p, input logic [7:0] exp [$]);
        logic a;
        logic [7:0] b;
        i_rtc_host_model.start();
        i_rtc_host_model.wbyte({DEV, 1'b0}, a);
        i_rtc_host_model.wbyte(p, a);
        i_rtc_host_model.start();
        i_rtc_host_model.wbyte({DEV, 1'b1}, a);
        check({7'h00, a}, 8'h01);
        foreach (exp[k])
        begin
            i_rtc_host_model.rbyte(k == exp.size() - 1, b);
            check(b, exp[k]);
        end
        i_rtc_host_model.stop();
    endtask
    // count low-going edges of the square-wave pin over 64 crystal periods
    task automatic wave_chk(input logic [7:0] ctl, input int lo, input int hi);
        int n;
        logic prev;
        reg_write(8'h0D, '{ctl});
        repeat (40) @(posedge clk);
        n = 0;
        prev = wave_oen;
        repeat (512)
        begin
            @(posedge clk);
            #1;
            if (prev === 1'b1 && wave_oen === 1'b0)
                n++;
            prev = wave_oen;
        end
        check({7'h00, n >= lo && n <= hi}, 8'h01);
    endtask
    task automatic end_test(input string name);
        $display("test %0s finished", name);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clk);
        #1 srst = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        check({6'h00, osc_fail, irq_oen}, 8'h03);
        check({5'h00, sda_out, irq_out, wave_out}, 8'h00);
        // wrap from 0f back to 00 included
        reg_read(8'h00, '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00,
            8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00});
        end_test("reset");
        // unimplemented bits dropped; seconds bit7 written 0 clears the fail flag
        reg_write(8'h02, '{8'h59, 8'h59, 8'hE3, 8'h31, 8'hF6, 8'hF2, 8'h96});
        reg_read(8'h02, '{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h96});
        check({7'h00, osc_fail}, 8'h00);
        end_test("time");
        reg_write(8'h09, '{8'h30, 8'hC5, 8'h15, 8'h83});
        reg_read(8'h09, '{8'h30, 8'h85, 8'h15, 8'h83});
        end_test("alarm fields");
        // flag written 1 stays clear, irq enable alone keeps the pin released
        reg_write(8'h01, '{8'h0A});
        reg_read(8'h01, '{8'h02});
        check({7'h00, irq_oen}, 8'h01);
        reg_write(8'h01, '{8'h02});
        reg_read(8'h01, '{8'h02});
        reg_write(8'h00, '{8'hFF});
        reg_read(8'h00, '{8'h00});
        i_rtc_host_model.start();
        i_rtc_host_model.wbyte({DEV ^ 7'h01, 1'b0}, ack);
        check({7'h00, ack}, 8'h00);
        i_rtc_host_model.stop();
        i_rtc_host_model.start();
        i_rtc_host_model.wbyte({DEV, 1'b0}, ack);
        i_rtc_host_model.wbyte(8'h10, ack);
        check({7'h00, ack}, 8'h00);
        i_rtc_host_model.stop();
        end_test("control and refusals");
        for (int r = 0; r < 5; r++)
            wave_chk(ctl_tab[r], lo_tab[r], hi_tab[r]);
        check({7'h00, wave_oen}, 8'h01);
        end_test("square wave");
        xtal_run = 1'b0;
        repeat (FAIL_CYC + 50) @(posedge clk);
        #1;
        check({7'h00, osc_fail}, 8'h01);
        reg_read(8'h02, '{8'hD9});
        xtal_run = 1'b1;
        end_test("oscillator fail");
        complete_run();
    end
endmodule

// File: rtc_defines.svh
// register map, field layout, reset values and timing for the calendar clock
// Operation
// - host reads and writes year, month, date, weekday, hour, minute and second counters.
// - any two-digit year divisible by four is leap; February then has 29 days.
// - one alarm raises the interrupt pin when enabled fields equal their settings.
// - every alarm field can join the match on its own.
// - fields switch in or out; excluded fields let the alarm repeat.
// - square-wave enable bit gates the square-wave pin.
// - square wave offers 1 Hz, 32 Hz, 1.024 kHz, 32.768 kHz from crystal.
// - all register access is two-wire serial, host master, device slave.
// - data line is only pulled low or released, never driven high.
// - a failed crystal sets the oscillator fail flag.
// - writing 0 clears the alarm flag; writing 1 leaves it unchanged.
// - an alarm field matches only while its disable bit is 0.
// - register addresses above 0FH get no acknowledge.
// - with square-wave enable at 0 the pin stays high impedance.
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH
`define REG_CTRL2 4'h1
`define REG_SEC 4'h2
`define REG_MIN 4'h3
`define REG_HOUR 4'h4
`define REG_DATE 4'h5
`define REG_WDAY 4'h6
`define REG_MON 4'h7
`define REG_YEAR 4'h8
`define REG_AL_MIN 4'h9
`define REG_AL_HOUR 4'hA
`define REG_AL_DATE 4'hB
`define REG_AL_WDAY 4'hC
`define REG_WAVE 4'hD
`define REG_ADDR_MAX 8'h0F
`define BIT_ALARM_FLAG 3
`define BIT_IRQ_EN 1
`define BIT_OSC_FAIL 7
`define BIT_FIELD_OFF 7
`define BIT_WAVE_EN 7
`define MASK_SEC 8'h7F
`define MASK_HOUR 8'h3F
`define MASK_WDAY 8'h07
`define MASK_MON 8'h1F
`define MASK_AL_HOUR 8'hBF
`define MASK_AL_WDAY 8'h87
`define SEC_MAX 8'h59
`define HOUR_MAX 8'h23
`define WDAY_MAX 8'h06
`define MON_MAX 8'h12
`define YEAR_MAX 8'h99
`define RST_WAVE_EN 1'b1
`define RST_RATE 2'h0
`define RST_OSC_FAIL 1'b1
`define RST_DAY_ONE 8'h01
`define RST_AL_FIELD 8'h80
`define RATE_32K 2'h0
`define RATE_1K 2'h1
`define RATE_32 2'h2
`define PRE_BIT_1K 4
`define PRE_BIT_32 9
`define PRE_BIT_1 14
// bus address, value is arbitrary
`define DEV_ADDR 7'h2C
`define CLK_PERIOD_PS 5000
`define OSC_FAIL_TIME_NS 100000
`define OSC_FAIL_CYC ((`OSC_FAIL_TIME_NS * 1000) / `CLK_PERIOD_PS)
`endif

// File: rtc_host_model.sv
// two-wire bus master model that drives the calendar clock's serial pins
`timescale 1ns/1ps
module rtc_host_model #(
    parameter real QTR = 16.0
) (
    // bus pins
    output logic o_scl,
    output logic o_sda_pull,
    input wire logic i_sda
);
    // scl stands high between frames, no free-running clock
    initial
    begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // start or repeated start: sda falls while scl is high
    task automatic start();
        #(QTR) o_sda_pull = 1'b0;
        #(QTR) o_scl = 1'b1;
        #(2 * QTR) o_sda_pull = 1'b1;
        #(2 * QTR) o_scl = 1'b0;
    endtask
    task automatic stop();
        #(QTR) o_sda_pull = 1'b1;
        #(QTR) o_scl = 1'b1;
        #(2 * QTR) o_sda_pull = 1'b0;
        #(2 * QTR);
    endtask
    // data set mid-low, sampled mid-high, so slave answers have settled
    // 64 ns bit period, far above the 400 kHz cap; the slave only needs a few clocks a phase
    task automatic bit_io(input logic tx, output logic rx);
        #(QTR) o_sda_pull = ~tx;
        #(QTR) o_scl = 1'b1;
        #(QTR) rx = i_sda;
        #(QTR) o_scl = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // last byte answered with nack to end the read
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(last, r);
    endtask
endmodule

// File: rtc_pkg.sv
// types of the calendar clock
package rtc_pkg;
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_addr = 3'b001,
        st_reg = 3'b010,
        st_ack = 3'b011,
        st_wr = 3'b100,
        st_rd = 3'b101,
        st_mack = 3'b110,
        st_ack_addr = 3'b111
    } link_state_t;

    typedef struct packed {
        logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, xtal_m, xtal_s, xtal_p;
        link_state_t st;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic read_dir;
        logic [3:0] ptr;
        logic sda_drv;
        logic [7:0] sec, min, hour, date, wday, mon, year;
        logic [7:0] al_min, al_hour, al_date, al_wday;
        logic osc_fail_flag, alarm_pending_flag, alarm_irq_enable, square_wave_enable;
        logic [1:0] square_wave_rate_select;
        logic [14:0] pre;
        logic [19:0] wdog;
        logic irq_drv, wave_drv;
    } rtc_state_t;
endpackage
